// ### hdl/vf_segment_serial_driver.sv
// serial segment shifter, latch, output mapping, dimming and apb registers
// Notes on behaviour
// - shift data in on clock while strobe low
// - first bit ends highest, shifting upward
// - 34 shift positions, 33 latches, 33 outputs
// - fixed matrix maps positions to outputs
// - strobe rising edge copies shifter into latches
// - strobe rising edge clears the shifter
// - strobe high blocks shifting
// - latched one drives output on
// - 34th clock start bit latches and clears
// - cascade output comes from the shifter
// - select input picks blanking or internal pwm
// - constant blank high gives full duty
// - outputs enabled only while blank high
// - pwm mode or test drives blank pin
// - 49 dimming steps out of 2048
// - internal dimming capped at 208 counts
// - oscillator near 500 kHz times the pwm
// - push-pull active high, outputs 7-14 strong
// - test mode turns cascade pin into input
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "vf_driver_params.svh"

module vf_segment_serial_driver
  import vf_driver_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link pins
  input wire logic shift_clk,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  input wire logic serial_cascade_i,
  output logic serial_cascade_o,
  output logic serial_cascade_oe,
  // dimming pins
  input wire logic dim_source_select,
  input wire logic osc_in,
  input wire logic blank_pwm_i,
  output logic blank_pwm_o,
  output logic blank_pwm_oe,
  // factory test selects
  input wire logic factory_test_sel_a,
  input wire logic factory_test_sel_b,
  // segment outputs
  output logic [`SEG_COUNT-1:0] seg_out,
  output logic [`SEG_COUNT-1:0] seg_high_current
);

  localparam int PIN_N = 8;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every pin is asynchronous to pclk
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync_a;
  logic [PIN_N-1:0] sync_b;
  logic sclk_last;
  logic strobe_last;

  assign pin_raw = {serial_cascade_i, factory_test_sel_b, factory_test_sel_a, blank_pwm_i,
                    osc_in, dim_source_select, latch_strobe, shift_clk};

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : gen_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= pin_raw[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  logic sclk_s;
  logic strobe_s;
  logic dimsel_s;
  logic osc_s;
  logic blank_s;
  logic test_a_s;
  logic test_b_s;
  logic cascade_in_s;
  logic data_s;
  logic data_a;

  assign sclk_s = sync_b[0];
  assign strobe_s = sync_b[1];
  assign dimsel_s = sync_b[2];
  assign osc_s = sync_b[3];
  assign blank_s = sync_b[4];
  assign test_a_s = sync_b[5];
  assign test_b_s = sync_b[6];
  assign cascade_in_s = sync_b[7];

  // data goes through the same two stages so it stays aligned with the clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_a <= 1'b0;
      data_s <= 1'b0;
    end else begin
      data_a <= serial_data_in;
      data_s <= data_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_last <= 1'b0;
      strobe_last <= 1'b0;
    end else begin
      sclk_last <= sclk_s;
      strobe_last <= strobe_s;
    end
  end

  logic shift_rise;
  logic strobe_rise;
  logic test_mode;
  dim_mode_type dim_mode;

  assign shift_rise = sclk_s & ~sclk_last;
  assign strobe_rise = strobe_s & ~strobe_last;
  assign test_mode = test_a_s & test_b_s;
  assign dim_mode = dimsel_s ? MODE_INT_PWM : MODE_EXT_BLANK;

  ////////////////////////////////////////////////////////////////////////////
  // shifter and latches
  logic [`SHIFT_LEN-1:0] shifter;
  logic [`SEG_COUNT-1:0] seg_latch;

  // a strobe edge in the same cycle as a clock edge wins: the shift is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shifter <= '0;
    end else if (strobe_rise) begin
      shifter <= '0;
    end else if (shift_rise && !strobe_s) begin
      shifter <= {shifter[`SHIFT_LEN-2:0], data_s};
    end
  end

  // position 33 holds only the start bit, so it is not latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_latch <= '0;
    end else if (strobe_rise) begin
      seg_latch <= shifter[`SEG_COUNT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_cascade_o <= 1'b0;
    end else begin
      serial_cascade_o <= shifter[`START_POS];
    end
  end

  assign serial_cascade_oe = ~test_mode;

  ////////////////////////////////////////////////////////////////////////////
  // output assignment matrix: a mask option, straight mapping here
  function automatic int output_assignment_matrix(input int out_idx);
    return out_idx;
  endfunction

  logic [`SEG_COUNT-1:0] seg_mapped;

  generate
    for (g = 0; g < `SEG_COUNT; g++) begin : gen_matrix
      assign seg_mapped[g] = seg_latch[output_assignment_matrix(g)];
      assign seg_high_current[g] = (g >= `HI_CUR_FIRST) && (g <= `HI_CUR_LAST);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // brightness
  dim_step_type analog_dim_level;
  logic pwm_level;
  logic osc_alive;
  logic pin_drives;
  logic seg_gate;

  vf_pwm_gen u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .osc_level(osc_s),
    .dim_step(analog_dim_level),
    .pwm_out(pwm_level),
    .osc_alive(osc_alive)
  );

  assign pin_drives = (dim_mode == MODE_INT_PWM) | test_mode;
  assign blank_pwm_oe = pin_drives;
  assign blank_pwm_o = pwm_level;
  // while the pin is an output its own input is meaningless, so pwm gates instead
  assign seg_gate = pin_drives ? pwm_level : blank_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_out <= '0;
    end else begin
      seg_out <= seg_mapped & {`SEG_COUNT{seg_gate}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle
  function automatic logic reg_known(input logic [`ADDR_WIDTH-1:0] a);
    return (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_LATCH_LO) ||
           (a == `REG_LATCH_HI) || (a == `REG_SHIFT_LO) || (a == `REG_SHIFT_HI);
  endfunction

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: next_prdata = {26'h0, analog_dim_level};
      `REG_STATUS: next_prdata = {27'h0, strobe_s, cascade_in_s, osc_alive, test_mode, dimsel_s};
      `REG_LATCH_LO: next_prdata = seg_latch[31:0];
      `REG_LATCH_HI: next_prdata = {31'h0, seg_latch[32]};
      `REG_SHIFT_LO: next_prdata = shifter[31:0];
      `REG_SHIFT_HI: next_prdata = {30'h0, shifter[33:32]};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_dim_level <= `CTRL_DIM_RESET;
    end else if (psel && penable && pwrite && paddr == `REG_CTRL) begin
      analog_dim_level <= pwdata[`CTRL_DIM_MSB:0];
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~reg_known(paddr);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_shift_in;
    @(posedge pclk) disable iff (!presetn)
    (shift_rise && !strobe_s && !strobe_rise) |=> (shifter == {$past(shifter[32:0]), $past(data_s)});
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift did not take data");

  property p_latch_copy;
    @(posedge pclk) disable iff (!presetn)
    strobe_rise |=> (seg_latch == $past(shifter[32:0]));
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch missed shifter");

  property p_shift_clear;
    @(posedge pclk) disable iff (!presetn)
    strobe_rise |=> (shifter == '0);
  endproperty
  a_shift_clear: assert property (p_shift_clear) else $error("shifter not cleared");

  property p_strobe_hold;
    @(posedge pclk) disable iff (!presetn)
    (strobe_s && !strobe_rise) |=> $stable(shifter);
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("shift while strobe high");

  property p_cascade_start;
    @(posedge pclk) disable iff (!presetn)
    (shifter[32] && shift_rise && !strobe_s && !strobe_rise) |=> ##1 serial_cascade_o;
  endproperty
  a_cascade_start: assert property (p_cascade_start) else $error("start bit not at cascade");

  property p_test_pin_input;
    @(posedge pclk) disable iff (!presetn)
    test_mode |-> !serial_cascade_oe;
  endproperty
  a_test_pin_input: assert property (p_test_pin_input) else $error("cascade driven in test");

  property p_blank_off;
    @(posedge pclk) disable iff (!presetn)
    (dim_mode == MODE_EXT_BLANK && !test_mode && !blank_s) |=> (seg_out == '0);
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("segments on while blanked");

  property p_full_duty;
    @(posedge pclk) disable iff (!presetn)
    (dim_mode == MODE_EXT_BLANK && !test_mode && blank_s) |=> (seg_out == $past(seg_mapped));
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("segments not following latch");

  property p_pwm_pin_out;
    @(posedge pclk) disable iff (!presetn)
    (dim_mode == MODE_INT_PWM) |-> (blank_pwm_oe && blank_pwm_o == pwm_level);
  endproperty
  a_pwm_pin_out: assert property (p_pwm_pin_out) else $error("pwm pin not driven");

  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn)
    !strobe_rise |=> $stable(seg_latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without strobe");

  property p_cascade_follow;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (serial_cascade_o == $past(shifter[`START_POS]));
  endproperty
  a_cascade_follow: assert property (p_cascade_follow) else $error("cascade not last position");

  // an auto-load strobe must fall again, or the next word would never latch
  property p_auto_clear;
    @(posedge pclk) disable iff (!presetn)
    strobe_rise |=> ##1 !serial_cascade_o;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("cascade high after load");

  property p_pwm_gate;
    @(posedge pclk) disable iff (!presetn)
    pin_drives |=> (seg_out == ($past(seg_mapped) & {`SEG_COUNT{$past(pwm_level)}}));
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("segments not gated by pwm");

endmodule

// ### hdl/vf_driver_params.svh
// constants for the vacuum fluorescent segment driver core
`ifndef VF_DRIVER_PARAMS_SVH
`define VF_DRIVER_PARAMS_SVH

// shifter, latch and output sizes
`define SHIFT_LEN 34
`define SEG_COUNT 33
`define START_POS 33
`define HI_CUR_FIRST 7
`define HI_CUR_LAST 14

// internal dimming
`define PWM_WIDTH 11
`define PWM_LAST 11'h7FF
`define PWM_MAX_ON 11'h0D0
`define DIM_STEPS 6'h31
`define STEP_A_LAST 6'h0C
`define STEP_A_BASE 11'h00C
`define STEP_B_FIRST 6'h0D
`define STEP_B_LAST 6'h18
`define STEP_B_BASE 11'h01A
// steps 25 and 26 already move by four, so the four-count run starts there
`define STEP_C_FIRST 6'h19
`define STEP_C_LAST 6'h23
`define STEP_C_BASE 11'h034
`define STEP_D_FIRST 6'h24
`define STEP_D_BASE 11'h060

// oscillator watchdog, derived from the nominal period
`define CLK_PERIOD_NS 4
`define OSC_PERIOD_NS 2000
`define OSC_CYCLES (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define OSC_TIMEOUT (4 * `OSC_CYCLES)
`define OSC_CNT_WIDTH 12

// register map (byte addresses)
`define ADDR_WIDTH 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LATCH_LO 12'h008
`define REG_LATCH_HI 12'h00C
`define REG_SHIFT_LO 12'h010
`define REG_SHIFT_HI 12'h014
`define CTRL_DIM_MSB 5
`define CTRL_DIM_RESET 6'h31

`endif

// ### hdl/vf_driver_pkg.sv
// types shared by the vacuum fluorescent segment driver core
package vf_driver_pkg;
  typedef logic [5:0] dim_step_type;
  typedef logic [10:0] pwm_count_type;
  typedef enum logic {MODE_EXT_BLANK, MODE_INT_PWM} dim_mode_type;
endpackage

// ### hdl/vf_pwm_gen.sv
// internal brightness pwm timed by the sampled oscillator input
`timescale 1ns/1ps
`include "vf_driver_params.svh"

module vf_pwm_gen
  import vf_driver_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // oscillator level, already synchronised
  input wire logic osc_level,
  // selected dimming step, 0 keeps the output off
  input dim_step_type dim_step,
  // pwm and oscillator health
  output logic pwm_out,
  output logic osc_alive
);

  logic osc_last;
  logic osc_tick;
  pwm_count_type period_cnt;
  pwm_count_type on_count;
  logic [`OSC_CNT_WIDTH-1:0] idle_cnt;

  // on-count for each step; anything above the last step clamps to the top
  function automatic pwm_count_type step_on_count(input dim_step_type s);
    pwm_count_type r;
    r = 11'h000;
    if (s == 6'h00) begin
      r = 11'h000;
    end else if (s <= `STEP_A_LAST) begin
      r = `STEP_A_BASE + {5'h00, s};
    end else if (s <= `STEP_B_LAST) begin
      r = `STEP_B_BASE + {4'h0, s - `STEP_B_FIRST, 1'b0};
    end else if (s <= `STEP_C_LAST) begin
      r = `STEP_C_BASE + {3'h0, s - `STEP_C_FIRST, 2'b00};
    end else if (s < `DIM_STEPS) begin
      r = `STEP_D_BASE + {2'h0, s - `STEP_D_FIRST, 3'b000};
    end else begin
      r = `PWM_MAX_ON;
    end
    return r;
  endfunction

  assign on_count = step_on_count(dim_step);
  assign osc_tick = osc_level & ~osc_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_last <= 1'b0;
    end else begin
      osc_last <= osc_level;
    end
  end

  // period of 2048 oscillator cycles, wrapping naturally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt <= 11'h000;
    end else if (osc_tick) begin
      period_cnt <= period_cnt + 11'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (period_cnt < on_count);
    end
  end

  // a stalled oscillator freezes the pwm; software can see that here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= '0;
      osc_alive <= 1'b0;
    end else if (osc_tick) begin
      idle_cnt <= '0;
      osc_alive <= 1'b1;
    end else if (idle_cnt == `OSC_CNT_WIDTH'(`OSC_TIMEOUT)) begin
      osc_alive <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + `OSC_CNT_WIDTH'(1);
    end
  end

  property p_pwm_period_wrap;
    @(posedge pclk) disable iff (!presetn)
    (osc_tick && period_cnt == `PWM_LAST) |=> (period_cnt == 11'h000);
  endproperty
  a_pwm_period_wrap: assert property (p_pwm_period_wrap) else $error("pwm period did not wrap");

  property p_pwm_never_above_cap;
    @(posedge pclk) disable iff (!presetn)
    (period_cnt >= `PWM_MAX_ON) |=> !pwm_out;
  endproperty
  a_pwm_never_above_cap: assert property (p_pwm_never_above_cap) else $error("pwm on past cap");

  property p_pwm_step_one;
    @(posedge pclk) disable iff (!presetn)
    (dim_step == 6'h01 && period_cnt == 11'h00C) |=> pwm_out;
  endproperty
  a_pwm_step_one: assert property (p_pwm_step_one) else $error("step one on-count wrong");

endmodule

// ### tb/vf_serial_host.sv
// host model that shifts segment words into the driver
`timescale 1ns/1ps

module vf_serial_host (
  // serial link pins
  output logic shift_clk,
  output logic serial_data_in,
  output logic latch_strobe
);
  initial begin
    shift_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // msb goes first; the clock rests low between words
  task automatic send_word(input logic [33:0] word, input int count);
    #3.3;
    for (int i = count - 1; i >= 0; i--) begin
      serial_data_in = word[i];
      #16 shift_clk = 1'b1;
      #16 shift_clk = 1'b0;
    end
    // released line flips so a stale bit never passes for fresh data
    serial_data_in = ~serial_data_in;
  endtask

  // strobe moves only while the clock is low
  task automatic load_pulse();
    #17.3 latch_strobe = 1'b1;
    #32 latch_strobe = 1'b0;
    #14.7;
  endtask

  task automatic set_strobe(input logic level);
    #9.3 latch_strobe = level;
    #6.7;
  endtask
endmodule

// ### tb/test_vf_segment_serial_driver.sv
// self-checking bench for the serial segment driver core
`timescale 1ns/1ps
`include "vf_driver_params.svh"

module test_vf_segment_serial_driver
  import vf_driver_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [`ADDR_WIDTH-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, shift_clk, serial_data_in, host_strobe, strobe_pin, fill;
  logic auto_mode = 0, serial_cascade_o, serial_cascade_oe, cascade_ext = 0, cascade_pin;
  logic dim_source_select = 0, osc_in = 0, blank_ext = 1, blank_pwm_o, blank_pwm_oe, blank_pin;
  logic factory_test_sel_a = 0, factory_test_sel_b = 0;
  logic [`SEG_COUNT-1:0] seg_out, seg_high_current, v;
  int errors = 0, total_checks = 0, hi;
  typedef struct {logic [11:0] addr; logic [31:0] data; logic err;} note_type;
  note_type notes[$];
  dim_step_type steps[6] = '{6'h00, 6'h01, 6'h1A, 6'h23, 6'h30, 6'h3F};
  pwm_count_type ons[6] = '{11'h000, 11'h00D, 11'h038, 11'h05C, 11'h0C0, 11'h0D0};

  // auto load ties the cascade output back onto the strobe
  assign strobe_pin = auto_mode ? serial_cascade_o : host_strobe;
  assign cascade_pin = serial_cascade_oe ? serial_cascade_o : cascade_ext;
  assign blank_pin = blank_pwm_oe ? blank_pwm_o : blank_ext;

  always #2 pclk = ~pclk;
  initial begin
    #1.5;
    forever #12 osc_in = ~osc_in;
  end

  vf_segment_serial_driver vf_segment_serial_driver_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clk(shift_clk), .serial_data_in(serial_data_in), .latch_strobe(strobe_pin),
    .serial_cascade_i(cascade_pin), .serial_cascade_o(serial_cascade_o),
    .serial_cascade_oe(serial_cascade_oe), .dim_source_select(dim_source_select), .osc_in(osc_in),
    .blank_pwm_i(blank_pin), .blank_pwm_o(blank_pwm_o), .blank_pwm_oe(blank_pwm_oe),
    .factory_test_sel_a(factory_test_sel_a), .factory_test_sel_b(factory_test_sel_b),
    .seg_out(seg_out), .seg_high_current(seg_high_current));

  vf_serial_host vf_serial_host_i (.shift_clk(shift_clk), .serial_data_in(serial_data_in),
    .latch_strobe(host_strobe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // for reads d is the expected data, noted before the transfer starts
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    if (!wr) notes.push_back('{a, d, err});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    if (n >= 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      chk($sformatf("read %h", notes[0].addr), {1'b0, notes[0].data}, {1'b0, prdata});
      chk("read error flag", {32'h0, notes[0].err}, {32'h0, pslverr});
      void'(notes.pop_front());
    end
  end

  initial begin
    #400000;
    errors++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(53));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("seg after reset", 33'h0, seg_out);
    chk("strong outputs", 33'h0_0000_7F80, seg_high_current);
    chk("cascade drive", 33'h1, {32'h0, serial_cascade_oe});
    chk("blank pin input", 33'h0, {32'h0, blank_pwm_oe});
    apb(1'b0, `REG_CTRL, 32'h31, 1'b0);
    apb(1'b0, 12'h018, 32'h0, 1'b1);
    v = {1'($urandom()), $urandom()};
    fill = 1'($urandom());
    vf_serial_host_i.send_word({fill, v}, 34);
    repeat (4) @(posedge pclk);
    chk("cascade bit", {32'h0, fill}, {32'h0, serial_cascade_o});
    vf_serial_host_i.load_pulse();
    repeat (4) @(posedge pclk);
    chk("seg direct", v, seg_out);
    apb(1'b0, `REG_LATCH_LO, v[31:0], 1'b0);
    apb(1'b0, `REG_SHIFT_HI, 32'h0, 1'b0);
    blank_ext <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("seg blanked", 33'h0, seg_out);
    blank_ext <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("seg full duty", v, seg_out);
    vf_serial_host_i.set_strobe(1'b1);
    vf_serial_host_i.send_word(34'h3_FFFF_FFFF, 34);
    vf_serial_host_i.set_strobe(1'b0);
    repeat (4) @(posedge pclk);
    chk("seg after empty load", 33'h0, seg_out);
    vf_serial_host_i.load_pulse();
    repeat (4) @(posedge pclk);
    chk("seg strobe held", 33'h0, seg_out);
    v = {1'($urandom()), $urandom()};
    auto_mode <= 1'b1;
    @(posedge pclk);
    vf_serial_host_i.send_word({1'b1, v}, 34);
    repeat (8) @(posedge pclk);
    chk("seg auto load", v, seg_out);
    apb(1'b0, `REG_SHIFT_LO, 32'h0, 1'b0);
    auto_mode <= 1'b0;
    dim_source_select <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("blank pin drive", 33'h1, {32'h0, blank_pwm_oe});
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `REG_CTRL, {26'h0, steps[i]}, 1'b0);
      repeat (8) @(posedge osc_in);
      hi = 0;
      repeat (2048) begin
        @(posedge osc_in);
        if (blank_pin === 1'b1) hi++;
      end
      chk("pwm on count", {22'h0, ons[i]}, 33'(hi));
    end
    @(posedge pclk);
    factory_test_sel_a <= 1'b1;
    factory_test_sel_b <= 1'b1;
    dim_source_select <= 1'b0;
    cascade_ext <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("cascade pin input", 33'h0, {32'h0, serial_cascade_oe});
    chk("blank pin in test", 33'h1, {32'h0, blank_pwm_oe});
    apb(1'b0, `REG_STATUS, 32'h0000_000E, 1'b0);
    results();
  end
endmodule
